//--- shared/pack_protect_pkg.sv
// constants shared by the pack protection control logic
package pack_protect_pkg;

	// ------------------------------------------------------------
	// register port geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int MUX_W  = 4;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_FLAG_CLR = 8'h08;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int CTRL_DIS_ON    = 0;
	localparam int CTRL_CHG_ON    = 1;
	localparam int CTRL_LMON_EN   = 2;
	localparam int CTRL_BIAS_FORCE = 3;
	localparam int CTRL_WAKE_POL  = 4;
	localparam int CTRL_MUX_LSB   = 8;

	// ------------------------------------------------------------
	// status and flag-clear fields (flag-clear uses the same bits)
	// ------------------------------------------------------------
	localparam int STAT_DIS_GATE  = 0;
	localparam int STAT_CHG_GATE  = 1;
	localparam int STAT_FAULT_LSB = 2;
	localparam int STAT_LOAD_FAIL = 5;
	localparam int STAT_OVER_TEMP = 6;
	localparam int STAT_WAKE      = 7;
	localparam int STAT_WAKE_EVT  = 8;
	localparam int STAT_BIAS      = 9;
	localparam int STAT_MUX_LSB   = 12;

	// fault index: short circuit, discharge overcurrent, charge overcurrent
	localparam int NUM_FAULT  = 3;
	localparam int FAULT_SC   = 0;
	localparam int FAULT_DOC  = 1;
	localparam int FAULT_COC  = 2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic             RST_WAKE_POL = 1'b1;
	localparam logic [MUX_W-1:0] RST_MUX_SEL  = 4'h0;

	// mux code that routes the thermistor divider to the analog output
	localparam logic [MUX_W-1:0] MUX_TEMP_SEL = 4'hc;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 5;
	localparam int SETTLE_TIME_NS = 100000;
	localparam logic [15:0] SETTLE_CYCLES =
		16'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// thermistor measurement sequence
	typedef enum logic [1:0] {
		TEMP_IDLE   = 2'b00,
		TEMP_SETTLE = 2'b01,
		TEMP_SAMPLE = 2'b11
	} temp_state_t;

endpackage : pack_protect_pkg

//--- rtl/wake_edge_detect.sv
// wake pin edge detection and level status with selectable polarity
`timescale 1ns/10ps
`default_nettype none

module wake_edge_detect (
	input  wire logic core_clk,
	input  wire logic reset_n,
	input  wire logic wake_input,
	input  wire logic wake_polarity_select,
	output var  logic wake_status,
	output var  logic wake_pulse
);

	logic prev_level;
	logic primed;
	logic next_prev_level;
	logic next_primed;
	logic next_wake_status;
	logic next_wake_pulse;

	// polarity applies to both the edge and the level; the raw pin is
	// remembered so that flipping polarity never fakes an edge
	always_comb begin
		next_prev_level  = wake_input;
		next_primed      = 1'b1;
		next_wake_status = wake_polarity_select ? wake_input : ~wake_input;
		if (wake_polarity_select) begin
			next_wake_pulse = primed & wake_input & ~prev_level;
		end else begin
			next_wake_pulse = primed & ~wake_input & prev_level;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_level  <= 1'b0;
			primed      <= 1'b0;
			wake_status <= 1'b0;
			wake_pulse  <= 1'b0;
		end else begin
			prev_level  <= next_prev_level;
			primed      <= next_primed;
			wake_status <= next_wake_status;
			wake_pulse  <= next_wake_pulse;
		end
	end

endmodule : wake_edge_detect

`default_nettype wire

//--- rtl/pack_protect_fet_wake_ctrl.sv
// battery pack protection control: gate drives, load release, thermistor, mux, wake
//
// Behaviour
// - discharge gate turns on only by host
// - charge gate turns on only by host
// - short or discharge overcurrent kills discharge gate
// - charge overcurrent kills charge gate
// - load monitor path on when enabled after short or discharge overcurrent
// - load fail clears when monitor drops low
// - mux output follows host select field
// - thermistor bias on during temperature measurement
// - force bit keeps thermistor bias on
// - bias on while any fault flag set
// - over-temperature when sense below bias/13
// - wake on edge, status follows level
// - polarity one: rising edge, high level
// - polarity zero: falling edge, low level
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module pack_protect_fet_wake_ctrl #(
	parameter logic [15:0] SETTLE_COUNT = pack_protect_pkg::SETTLE_CYCLES
) (
	input  wire logic                              core_clk,
	input  wire logic                              reset_n,
	input  wire logic [pack_protect_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [pack_protect_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                              reg_write,
	input  wire logic                              reg_read,
	output var  logic [pack_protect_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                              short_circuit_det,
	input  wire logic                              discharge_oc_det,
	input  wire logic                              charge_oc_det,
	input  wire logic                              load_monitor_high,
	input  wire logic                              thermistor_sense_low,
	input  wire logic                              wake_input,
	output var  logic                              discharge_gate_drive,
	output var  logic                              charge_gate_drive,
	output var  logic                              load_monitor_path_en,
	output var  logic                              load_fail_flag,
	output var  logic                              thermistor_bias_out,
	output var  logic [pack_protect_pkg::MUX_W-1:0]  analog_mux_sel,
	output var  logic                              external_over_temp,
	output var  logic                              wake_request,
	output var  logic                              wake_status
);

	// ------------------------------------------------------------
	// register access decode
	// ------------------------------------------------------------
	logic wr_control;
	logic wr_flag_clr;

	assign wr_control  = reg_write && (reg_addr == pack_protect_pkg::OFS_CONTROL);
	assign wr_flag_clr = reg_write && (reg_addr == pack_protect_pkg::OFS_FLAG_CLR);

	// ------------------------------------------------------------
	// host control bits
	// ------------------------------------------------------------
	logic                              load_monitor_enable;
	logic                              bias_force;
	logic                              wake_polarity_select;
	logic                              next_load_monitor_enable;
	logic                              next_bias_force;
	logic                              next_wake_polarity_select;
	logic [pack_protect_pkg::MUX_W-1:0] next_analog_mux_sel;

	always_comb begin
		next_load_monitor_enable  = load_monitor_enable;
		next_bias_force           = bias_force;
		next_wake_polarity_select = wake_polarity_select;
		next_analog_mux_sel       = analog_mux_sel;
		if (wr_control) begin
			next_load_monitor_enable  = reg_wdata[pack_protect_pkg::CTRL_LMON_EN];
			next_bias_force           = reg_wdata[pack_protect_pkg::CTRL_BIAS_FORCE];
			next_wake_polarity_select = reg_wdata[pack_protect_pkg::CTRL_WAKE_POL];
			next_analog_mux_sel       =
				reg_wdata[pack_protect_pkg::CTRL_MUX_LSB +: pack_protect_pkg::MUX_W];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			load_monitor_enable  <= 1'b0;
			bias_force           <= 1'b0;
			wake_polarity_select <= pack_protect_pkg::RST_WAKE_POL;
			analog_mux_sel       <= pack_protect_pkg::RST_MUX_SEL;
		end else begin
			load_monitor_enable  <= next_load_monitor_enable;
			bias_force           <= next_bias_force;
			wake_polarity_select <= next_wake_polarity_select;
			analog_mux_sel       <= next_analog_mux_sel;
		end
	end

	// ------------------------------------------------------------
	// fault flags
	// ------------------------------------------------------------
	logic [pack_protect_pkg::NUM_FAULT-1:0] fault_det;
	logic [pack_protect_pkg::NUM_FAULT-1:0] fault_clr;
	logic [pack_protect_pkg::NUM_FAULT-1:0] fault_flag;
	logic [pack_protect_pkg::NUM_FAULT-1:0] next_fault_flag;

	assign fault_det[pack_protect_pkg::FAULT_SC]  = short_circuit_det;
	assign fault_det[pack_protect_pkg::FAULT_DOC] = discharge_oc_det;
	assign fault_det[pack_protect_pkg::FAULT_COC] = charge_oc_det;
	assign fault_clr = wr_flag_clr ?
		reg_wdata[pack_protect_pkg::STAT_FAULT_LSB +: pack_protect_pkg::NUM_FAULT] : 3'h0;

	// a fault in the same cycle as its clear keeps the flag set
	genvar gi;
	generate
		for (gi = 0; gi < pack_protect_pkg::NUM_FAULT; gi++) begin : g_fault
			always_comb begin
				next_fault_flag[gi] = fault_det[gi] | (fault_flag[gi] & ~fault_clr[gi]);
			end

			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					fault_flag[gi] <= 1'b0;
				end else begin
					fault_flag[gi] <= next_fault_flag[gi];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// gate drives
	// ------------------------------------------------------------
	logic dis_trip;
	logic chg_trip;
	logic next_discharge_gate_drive;
	logic next_charge_gate_drive;

	assign dis_trip = short_circuit_det | discharge_oc_det;
	assign chg_trip = charge_oc_det;

	// a trip outranks an on command in the same cycle; once tripped the gate
	// waits for a fresh on command, a lingering control value does not count
	always_comb begin
		next_discharge_gate_drive = discharge_gate_drive;
		next_charge_gate_drive    = charge_gate_drive;
		if (wr_control) begin
			next_discharge_gate_drive = reg_wdata[pack_protect_pkg::CTRL_DIS_ON];
			next_charge_gate_drive    = reg_wdata[pack_protect_pkg::CTRL_CHG_ON];
		end
		if (dis_trip) begin
			next_discharge_gate_drive = 1'b0;
		end
		if (chg_trip) begin
			next_charge_gate_drive = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			discharge_gate_drive <= 1'b0;
			charge_gate_drive    <= 1'b0;
		end else begin
			discharge_gate_drive <= next_discharge_gate_drive;
			charge_gate_drive    <= next_charge_gate_drive;
		end
	end

	// ------------------------------------------------------------
	// load release monitoring
	// ------------------------------------------------------------
	logic next_load_fail_flag;
	logic next_load_monitor_path_en;

	// the release can only be seen through the monitor path, so the
	// comparator counts only while that path is switched in
	always_comb begin
		next_load_fail_flag = load_fail_flag;
		if (load_monitor_path_en && !load_monitor_high) begin
			next_load_fail_flag = 1'b0;
		end
		if (dis_trip) begin
			next_load_fail_flag = 1'b1;
		end
		next_load_monitor_path_en = next_load_fail_flag & next_load_monitor_enable;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			load_fail_flag       <= 1'b0;
			load_monitor_path_en <= 1'b0;
		end else begin
			load_fail_flag       <= next_load_fail_flag;
			load_monitor_path_en <= next_load_monitor_path_en;
		end
	end

	// ------------------------------------------------------------
	// thermistor measurement sequence
	// ------------------------------------------------------------
	pack_protect_pkg::temp_state_t temp_state;
	pack_protect_pkg::temp_state_t next_temp_state;
	logic [15:0]                   settle_cnt;
	logic [15:0]                   next_settle_cnt;
	logic                          next_thermistor_bias_out;
	logic                          next_external_over_temp;

	// selecting the thermistor channel starts a measurement; the divider
	// must settle before the sense comparator is trusted
	always_comb begin
		next_temp_state = temp_state;
		next_settle_cnt = settle_cnt;
		case (temp_state)
			pack_protect_pkg::TEMP_IDLE: begin
				next_settle_cnt = 16'h0000;
				if (analog_mux_sel == pack_protect_pkg::MUX_TEMP_SEL) begin
					next_temp_state = pack_protect_pkg::TEMP_SETTLE;
				end
			end
			pack_protect_pkg::TEMP_SETTLE: begin
				next_settle_cnt = settle_cnt + 16'h0001;
				if (analog_mux_sel != pack_protect_pkg::MUX_TEMP_SEL) begin
					next_temp_state = pack_protect_pkg::TEMP_IDLE;
				end else if (settle_cnt >= SETTLE_COUNT - 16'h0001) begin
					next_temp_state = pack_protect_pkg::TEMP_SAMPLE;
				end
			end
			pack_protect_pkg::TEMP_SAMPLE: begin
				if (analog_mux_sel != pack_protect_pkg::MUX_TEMP_SEL) begin
					next_temp_state = pack_protect_pkg::TEMP_IDLE;
				end
			end
			default: begin
				next_temp_state = pack_protect_pkg::TEMP_IDLE;
			end
		endcase

		next_thermistor_bias_out = (next_temp_state != pack_protect_pkg::TEMP_IDLE)
			| next_bias_force
			| (|next_fault_flag);

		// comparator trips at one thirteenth of the bias level
		next_external_over_temp = (next_temp_state == pack_protect_pkg::TEMP_SAMPLE)
			& thermistor_sense_low;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			temp_state          <= pack_protect_pkg::TEMP_IDLE;
			settle_cnt          <= 16'h0000;
			thermistor_bias_out <= 1'b0;
			external_over_temp  <= 1'b0;
		end else begin
			temp_state          <= next_temp_state;
			settle_cnt          <= next_settle_cnt;
			thermistor_bias_out <= next_thermistor_bias_out;
			external_over_temp  <= next_external_over_temp;
		end
	end

	// ------------------------------------------------------------
	// wake input
	// ------------------------------------------------------------
	logic wake_event;
	logic next_wake_event;

	wake_edge_detect u_wake (
		.core_clk             (core_clk),
		.reset_n              (reset_n),
		.wake_input           (wake_input),
		.wake_polarity_select (wake_polarity_select),
		.wake_status          (wake_status),
		.wake_pulse           (wake_request)
	);

	// sticky record of the edge, since the status bit is only a level
	always_comb begin
		next_wake_event = wake_request |
			(wake_event & ~(wr_flag_clr & reg_wdata[pack_protect_pkg::STAT_WAKE_EVT]));
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_event <= 1'b0;
		end else begin
			wake_event <= next_wake_event;
		end
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	logic [pack_protect_pkg::DATA_W-1:0] next_reg_rdata;

	// data stands for exactly the cycle after the read strobe
	always_comb begin
		next_reg_rdata = 32'h0000_0000;
		if (reg_read) begin
			case (reg_addr)
				pack_protect_pkg::OFS_CONTROL: begin
					next_reg_rdata[pack_protect_pkg::CTRL_DIS_ON]     = discharge_gate_drive;
					next_reg_rdata[pack_protect_pkg::CTRL_CHG_ON]     = charge_gate_drive;
					next_reg_rdata[pack_protect_pkg::CTRL_LMON_EN]    = load_monitor_enable;
					next_reg_rdata[pack_protect_pkg::CTRL_BIAS_FORCE] = bias_force;
					next_reg_rdata[pack_protect_pkg::CTRL_WAKE_POL]   = wake_polarity_select;
					next_reg_rdata[pack_protect_pkg::CTRL_MUX_LSB +: pack_protect_pkg::MUX_W] =
						analog_mux_sel;
				end
				pack_protect_pkg::OFS_STATUS: begin
					next_reg_rdata[pack_protect_pkg::STAT_DIS_GATE]  = discharge_gate_drive;
					next_reg_rdata[pack_protect_pkg::STAT_CHG_GATE]  = charge_gate_drive;
					next_reg_rdata[pack_protect_pkg::STAT_FAULT_LSB +: pack_protect_pkg::NUM_FAULT] =
						fault_flag;
					next_reg_rdata[pack_protect_pkg::STAT_LOAD_FAIL] = load_fail_flag;
					next_reg_rdata[pack_protect_pkg::STAT_OVER_TEMP] = external_over_temp;
					next_reg_rdata[pack_protect_pkg::STAT_WAKE]      = wake_status;
					next_reg_rdata[pack_protect_pkg::STAT_WAKE_EVT]  = wake_event;
					next_reg_rdata[pack_protect_pkg::STAT_BIAS]      = thermistor_bias_out;
					next_reg_rdata[pack_protect_pkg::STAT_MUX_LSB +: 2] = temp_state;
				end
				default: begin
					next_reg_rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

endmodule : pack_protect_fet_wake_ctrl

`default_nettype wire

//--- sim/pack_protect_assertions.sv
// concurrent checks on the pack protection control ports
`timescale 1ns/10ps
`default_nettype none

module pack_protect_checker #(
	parameter logic [15:0] SETTLE_COUNT = pack_protect_pkg::SETTLE_CYCLES
) (
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic        short_circuit_det,
	input wire logic        discharge_oc_det,
	input wire logic        charge_oc_det,
	input wire logic        load_monitor_high,
	input wire logic        thermistor_sense_low,
	input wire logic        wake_input,
	input wire logic        discharge_gate_drive,
	input wire logic        charge_gate_drive,
	input wire logic        load_monitor_path_en,
	input wire logic        load_fail_flag,
	input wire logic        thermistor_bias_out,
	input wire logic [3:0]  analog_mux_sel,
	input wire logic        external_over_temp,
	input wire logic        wake_request,
	input wire logic        wake_status
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	logic ctrl_wr;
	assign ctrl_wr = reg_write && reg_addr == pack_protect_pkg::OFS_CONTROL;

	// ------------------------------------------------------------
	// gate drives and bias on fault
	// ------------------------------------------------------------
	dis_by_host_a: assert property ($rose(discharge_gate_drive) |-> $past(ctrl_wr && reg_wdata[0]))
		else $error("discharge gate rose without host command");
	chg_by_host_a: assert property ($rose(charge_gate_drive) |-> $past(ctrl_wr && reg_wdata[1]))
		else $error("charge gate rose without host command");
	dis_trip_a: assert property ((short_circuit_det || discharge_oc_det) |=> !discharge_gate_drive)
		else $error("discharge gate not off after fault");
	chg_trip_a: assert property (charge_oc_det |=> !charge_gate_drive)
		else $error("charge gate not off after fault");
	bias_on_fault_a: assert property (short_circuit_det |-> ##[1:2] thermistor_bias_out)
		else $error("bias not on after fault flag");

	// ------------------------------------------------------------
	// load release, mux, temperature, wake
	// ------------------------------------------------------------
	path_needs_fail_a: assert property (load_monitor_path_en |-> load_fail_flag)
		else $error("monitor path on without load fail");
	load_release_a: assert property (load_monitor_path_en && !load_monitor_high && !short_circuit_det
		&& !discharge_oc_det |=> !load_fail_flag)
		else $error("load fail not cleared after release");
	mux_follow_a: assert property (ctrl_wr |=> analog_mux_sel == $past(reg_wdata[11:8]))
		else $error("mux select does not follow control write");
	over_temp_a: assert property (external_over_temp |-> $past(thermistor_sense_low))
		else $error("over temperature without low sense");
	wake_level_a: assert property (wake_request |-> wake_status)
		else $error("wake pulse with wrong level status");
	wake_pulse_a: assert property (wake_request |=> !wake_request)
		else $error("wake pulse longer than one cycle");

	cover property (short_circuit_det ##1 !discharge_gate_drive);
	cover property (wake_request);
	cover property (external_over_temp);
endmodule : pack_protect_checker

bind pack_protect_fet_wake_ctrl pack_protect_checker #(.SETTLE_COUNT(SETTLE_COUNT)) u_chk (.*);

`default_nettype wire

//--- sim/host_model.sv
// host controller model driving the register port
`timescale 1ns/10ps
`default_nettype none

module host_model (
	input  wire logic        core_clk,
	output var  logic [7:0]  reg_addr,
	output var  logic [31:0] reg_wdata,
	output var  logic        reg_write,
	output var  logic        reg_read,
	input  wire logic [31:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end

	task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_write <= 1'b0;
		reg_wdata <= ~d;
		#1;
	endtask : write_reg

	// data stand only in the cycle after the strobe
	task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : read_reg

	// read back gate state, then clear one gate bit
	task automatic gate_off(input int bit_n);
		logic [31:0] c;
		read_reg(pack_protect_pkg::OFS_CONTROL, c);
		c[bit_n] = 1'b0;
		write_reg(pack_protect_pkg::OFS_CONTROL, c);
	endtask : gate_off

	task automatic cell_undervoltage();
		gate_off(pack_protect_pkg::CTRL_DIS_ON);
	endtask : cell_undervoltage

	task automatic cell_overvoltage();
		gate_off(pack_protect_pkg::CTRL_CHG_ON);
	endtask : cell_overvoltage
endmodule : host_model

`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the pack protection control block
`timescale 1ns/10ps
`default_nettype none

module testbench;
	localparam logic [15:0] SETTLE = 16'h0008;
	localparam logic [7:0]  CTL = pack_protect_pkg::OFS_CONTROL;
	localparam logic [7:0]  STA = pack_protect_pkg::OFS_STATUS;

	typedef struct packed {
		logic [31:0] wdata;
		logic        dis;
		logic        chg;
		logic [3:0]  mux;
	} row_t;
	localparam row_t ROWS [5] = '{
		'{32'h0000_0011, 1'b1, 1'b0, 4'h0}, '{32'h0000_0512, 1'b0, 1'b1, 4'h5},
		'{32'h0000_0f13, 1'b1, 1'b1, 4'hf}, '{32'h0000_0a10, 1'b0, 1'b0, 4'ha},
		'{32'h0000_0313, 1'b1, 1'b1, 4'h3}};

	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic reg_write, reg_read, wake_request, wake_status, external_over_temp;
	logic short_circuit_det = 1'b0, discharge_oc_det = 1'b0, charge_oc_det = 1'b0;
	logic load_monitor_high = 1'b1, thermistor_sense_low = 1'b0, wake_input = 1'b0;
	logic discharge_gate_drive, charge_gate_drive, load_monitor_path_en, load_fail_flag;
	logic thermistor_bias_out;
	logic [3:0] analog_mux_sel;
	int error_cnt = 0;
	int n_compared = 0;
	int pulses;

	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

	pack_protect_fet_wake_ctrl #(.SETTLE_COUNT(SETTLE)) DUT (.*);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	// one-cycle detector pulse, then let the trip land
	task automatic pulse_det(input int which);
		@(posedge core_clk);
		case (which)
			pack_protect_pkg::FAULT_SC: begin
				short_circuit_det <= 1'b1;
			end
			pack_protect_pkg::FAULT_DOC: begin
				discharge_oc_det <= 1'b1;
			end
			default: begin
				charge_oc_det <= 1'b1;
			end
		endcase
		@(posedge core_clk);
		short_circuit_det <= 1'b0;
		discharge_oc_det  <= 1'b0;
		charge_oc_det     <= 1'b0;
		tick(1);
	endtask : pulse_det

	task automatic wake_to(input logic v);
		@(posedge core_clk);
		wake_input <= v;
		pulses = 0;
		repeat (4) begin
			tick(1);
			if (wake_request === 1'b1) pulses++;
		end
	endtask : wake_to

	initial begin
		#50000;
		error_cnt++;
		end_of_test();
	end

	initial begin
		tick(2);
		check({discharge_gate_drive, charge_gate_drive}, 32'h0);
		@(posedge core_clk);
		reset_n <= 1'b1;
		host.read_reg(CTL, rd);
		check(rd, 32'h0000_0010);
		host.read_reg(8'h40, rd);
		check(rd, 32'h0);
		host.write_reg(STA, 32'hffff_ffff);
		tick(1);
		check(discharge_gate_drive, 1'b0);
		// ------------------------------------------------------------
		// host command table
		// ------------------------------------------------------------
		foreach (ROWS[i]) begin
			host.write_reg(CTL, ROWS[i].wdata);
			check({discharge_gate_drive, charge_gate_drive}, {ROWS[i].dis, ROWS[i].chg});
			check(analog_mux_sel, ROWS[i].mux);
		end
		// ------------------------------------------------------------
		// autonomous trips and load release
		// ------------------------------------------------------------
		pulse_det(pack_protect_pkg::FAULT_SC);
		check({discharge_gate_drive, charge_gate_drive}, 32'h1);
		check({load_fail_flag, thermistor_bias_out}, 32'h3);
		host.read_reg(STA, rd);
		check(rd[4:2], 3'h1);
		tick(3);
		check(discharge_gate_drive, 1'b0);
		host.write_reg(CTL, 32'h0000_0016);
		tick(1);
		check(load_monitor_path_en, 1'b1);
		@(posedge core_clk);
		load_monitor_high <= 1'b0;
		tick(3);
		check(load_fail_flag, 1'b0);
		host.write_reg(pack_protect_pkg::OFS_FLAG_CLR, 32'h0000_001c);
		tick(2);
		check(thermistor_bias_out, 1'b0);
		host.write_reg(CTL, 32'h0000_0013);
		check(discharge_gate_drive, 1'b1);
		pulse_det(pack_protect_pkg::FAULT_COC);
		check({discharge_gate_drive, charge_gate_drive}, 32'h2);
		pulse_det(pack_protect_pkg::FAULT_DOC);
		check(discharge_gate_drive, 1'b0);
		host.read_reg(STA, rd);
		check(rd[4:2], 3'h6);
		host.write_reg(pack_protect_pkg::OFS_FLAG_CLR, 32'h0000_001c);
		host.write_reg(CTL, 32'h0000_0013);
		host.cell_undervoltage();
		check({discharge_gate_drive, charge_gate_drive}, 32'h1);
		host.cell_overvoltage();
		check(charge_gate_drive, 1'b0);
		// ------------------------------------------------------------
		// thermistor bias and over-temperature
		// ------------------------------------------------------------
		tick(2);
		check(thermistor_bias_out, 1'b0);
		host.write_reg(CTL, 32'h0000_0c10);
		tick(2);
		check(thermistor_bias_out, 1'b1);
		@(posedge core_clk);
		thermistor_sense_low <= 1'b1;
		tick(SETTLE + 4);
		check(external_over_temp, 1'b1);
		host.write_reg(CTL, 32'h0000_0010);
		tick(2);
		check({thermistor_bias_out, external_over_temp}, 32'h0);
		@(posedge core_clk);
		thermistor_sense_low <= 1'b0;
		host.write_reg(CTL, 32'h0000_0018);
		tick(2);
		check(thermistor_bias_out, 1'b1);
		// ------------------------------------------------------------
		// wake input in both polarities
		// ------------------------------------------------------------
		host.write_reg(CTL, 32'h0000_0010);
		wake_to(1'b1);
		check({pulses[7:0], wake_status}, {8'h1, 1'b1});
		wake_to(1'b0);
		check({pulses[7:0], wake_status}, {8'h0, 1'b0});
		host.write_reg(CTL, 32'h0000_0000);
		tick(2);
		check(wake_status, 1'b1);
		wake_to(1'b1);
		check({pulses[7:0], wake_status}, {8'h0, 1'b0});
		wake_to(1'b0);
		check({pulses[7:0], wake_status}, {8'h1, 1'b1});
		host.read_reg(STA, rd);
		check(rd[8:7], 2'h3);
		host.write_reg(pack_protect_pkg::OFS_FLAG_CLR, 32'h0000_0100);
		host.read_reg(STA, rd);
		check(rd[8:7], 2'h1);
		// ------------------------------------------------------------
		// reset in mid-run
		// ------------------------------------------------------------
		@(posedge core_clk);
		reset_n <= 1'b0;
		tick(1);
		check({discharge_gate_drive, charge_gate_drive, load_fail_flag}, 32'h0);
		@(posedge core_clk);
		reset_n <= 1'b1;
		host.read_reg(CTL, rd);
		check(rd, 32'h0000_0010);
		end_of_test();
	end
endmodule : testbench

`default_nettype wire
